// File: atx_defines.svh
// timing counts, opcodes and fifo figures for the arinc transmitter
// assumes a 20 MHz system clock and a 1 MHz transmit timebase derived from it
//
// Overview of operation
// - opcode 0x0c appends word to fifo in order
// - fifo holds 32 words; empty flag when none
// - half flag set above 16 words
// - full flag and full pin at 32 words
// - writes while full are dropped
// - parity on: bit 32 makes odd parity
// - parity off: all 32 bits sent unchanged
// - loopback feeds receiver one, inverted receiver two
// - loopback holds bus outputs at null
// - auto off: opcode 0x40 starts transmission
// - run continues until fifo empty
// - auto off: later words wait for start
// - auto on: start at chip select rise
// - tristate floats drivers, rest keeps running
// - one positive, zero negative, null zero differential
// - rate bit picks speed and slope
// - bit is 10/80 ticks, half data half null
// - word gap 40/320 ticks of null
// - irq pulse lasts one timebase period
`ifndef ATX_DEFINES_SVH
`define ATX_DEFINES_SVH
`define ATX_CLK_PERIOD_NS 50
`define ATX_TB_PERIOD_NS  1000
`define ATX_TB_DIV        (`ATX_TB_PERIOD_NS / `ATX_CLK_PERIOD_NS)
`define ATX_OP_WRITE      8'h0c
`define ATX_OP_START      8'h40
`define ATX_DEPTH         32
`define ATX_HALF_LEVEL    16
`define ATX_WORD_BITS     32
`define ATX_LABEL_BITS    8
`define ATX_HI_BIT_TICKS  10
`define ATX_LO_BIT_TICKS  80
`define ATX_HI_GAP_TICKS  40
`define ATX_LO_GAP_TICKS  320
`define ATX_IRQ_CYCLES    `ATX_TB_DIV
`endif

// File: atx_pkg.sv
// types shared by the arinc transmitter
// assumes atx_defines.svh is on the include path
`include "atx_defines.svh"
package atx_pkg;
    typedef enum logic [1:0] {ATX_IDLE, ATX_BIT, ATX_GAP} atx_phase_t;

    // pos high = one, neg high = zero, both low = null
    typedef struct packed {
        logic pos;
        logic neg;
    } atx_line_t;

    typedef struct packed {
        logic [`ATX_DEPTH-1:0][`ATX_WORD_BITS-1:0] mem;
        logic [4:0]                                wr_ptr;
        logic [4:0]                                rd_ptr;
        logic [5:0]                                count;
        atx_phase_t                                phase;
        logic                                      running;
        logic [4:0]                                div;
        logic [8:0]                                tick_cnt;
        logic [4:0]                                bit_idx;
        logic [`ATX_WORD_BITS-1:0]                 shreg;
        logic [4:0]                                irq_cnt;
        logic                                      empty;
        logic                                      half;
        logic                                      full;
        atx_line_t                                 bus;
        atx_line_t                                 rx1;
        atx_line_t                                 rx2;
        logic                                      oe;
        logic                                      slow;
        logic                                      irq;
    } atx_state_t;
endpackage : atx_pkg

// File: atx_transmitter.sv
// arinc 429 transmit path: 32 word fifo, parity, serialiser and line control
// assumes the spi front end decodes opcodes and pulses cmd_valid and cs_rise
// on this clock; control bits come from the transmit control register
`timescale 1ns/1ps
`include "atx_defines.svh"
module atx_transmitter
    import atx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [31:0] cmd_data,
    input  wire logic        cs_rise,
    input  wire logic        parity_insert_enable,
    input  wire logic        loopback_test_enable,
    input  wire logic        auto_send_enable,
    input  wire logic        driver_tristate_enable,
    input  wire logic        rate_slow,
    output logic             tx_fifo_empty_flag,
    output logic             tx_fifo_half_flag,
    output logic             tx_fifo_full_flag,
    output logic             tx_full_pin,
    output logic             bus_out_pos,
    output logic             bus_out_neg,
    output logic             protected_out_pos,
    output logic             protected_out_neg,
    output logic             driver_oe,
    output logic             slow_slope,
    output atx_line_t        receiver_one,
    output atx_line_t        receiver_two,
    output logic             tx_idle_irq_pin
);

    localparam atx_line_t LINE_NULL = 2'h0;

    atx_state_t s;
    atx_state_t next_s;
    logic       push;
    logic       pop;
    logic       start;
    logic       tick;
    logic [8:0] bit_ticks;
    logic [8:0] half_ticks;
    logic [8:0] gap_ticks;
    logic [31:0] head;
    atx_line_t  line;

    // bit position on the wire: label msb first, then the rest ascending
    function automatic logic [4:0] wire_order(input logic [4:0] i);
        return (i < 5'(`ATX_LABEL_BITS)) ? 5'(`ATX_LABEL_BITS - 1) - i : i;
    endfunction : wire_order

    always_comb begin
        next_s = s;
        pop = 1'b0;
        head = s.mem[s.rd_ptr];
        push = cmd_valid && (cmd_opcode == `ATX_OP_WRITE) && !s.full;
        // auto mode still honours an explicit start opcode
        start = (cmd_valid && (cmd_opcode == `ATX_OP_START))
              || (cs_rise && auto_send_enable);
        tick = (s.div == 5'(`ATX_TB_DIV - 1));
        next_s.div = tick ? 5'h00 : s.div + 5'h01;
        bit_ticks = rate_slow ? 9'(`ATX_LO_BIT_TICKS) : 9'(`ATX_HI_BIT_TICKS);
        half_ticks = bit_ticks >> 1;
        gap_ticks = rate_slow ? 9'(`ATX_LO_GAP_TICKS) : 9'(`ATX_HI_GAP_TICKS);

        unique case (s.phase)
            ATX_IDLE: begin
                if (s.running && (s.count != 6'h00)) begin
                    pop = 1'b1;
                end
            end
            ATX_BIT: begin
                if (tick) begin
                    // >= so a rate change mid-bit cannot run the count past its end
                    if (s.tick_cnt >= bit_ticks - 9'h001) begin
                        next_s.tick_cnt = 9'h000;
                        if (s.bit_idx == 5'(`ATX_WORD_BITS - 1)) begin
                            next_s.phase = ATX_GAP;
                        end else begin
                            next_s.bit_idx = s.bit_idx + 5'h01;
                        end
                    end else begin
                        next_s.tick_cnt = s.tick_cnt + 9'h001;
                    end
                end
            end
            ATX_GAP: begin
                if (tick) begin
                    if (s.tick_cnt >= gap_ticks - 9'h001) begin
                        next_s.tick_cnt = 9'h000;
                        if (s.running && (s.count != 6'h00)) begin
                            pop = 1'b1;
                        end else begin
                            next_s.phase = ATX_IDLE;
                            next_s.irq_cnt = 5'(`ATX_IRQ_CYCLES);
                        end
                    end else begin
                        next_s.tick_cnt = s.tick_cnt + 9'h001;
                    end
                end
            end
        endcase

        if (pop) begin
            next_s.phase = ATX_BIT;
            next_s.tick_cnt = 9'h000;
            next_s.bit_idx = 5'h00;
            next_s.rd_ptr = s.rd_ptr + 5'h01;
            next_s.shreg = head;
            if (parity_insert_enable) begin
                next_s.shreg[31] = ~^head[30:0];
            end // else bit 32 goes out as loaded
            // the run ends the moment the fifo drains; later words wait
            if ((s.count == 6'h01) && !push) begin
                next_s.running = 1'b0;
            end
        end
        // start after the pop so a start in the same cycle is not lost
        if (start && ((s.count != 6'h00) || push)) begin
            next_s.running = 1'b1;
        end

        if (push) begin
            next_s.mem[s.wr_ptr] = cmd_data;
            next_s.wr_ptr = s.wr_ptr + 5'h01;
        end
        next_s.count = s.count + {5'h00, push} - {5'h00, pop};
        next_s.empty = (next_s.count == 6'h00);
        next_s.half = (next_s.count > 6'(`ATX_HALF_LEVEL));
        next_s.full = (next_s.count == 6'(`ATX_DEPTH));

        // data for the first half of each bit, null otherwise
        line = LINE_NULL;
        if ((next_s.phase == ATX_BIT) && (next_s.tick_cnt < half_ticks)) begin
            line.pos = next_s.shreg[wire_order(next_s.bit_idx)];
            line.neg = ~line.pos;
        end
        next_s.bus = loopback_test_enable ? LINE_NULL : line;
        next_s.rx1 = loopback_test_enable ? line : LINE_NULL;
        next_s.rx2 = loopback_test_enable ? {line.neg, line.pos} : LINE_NULL;
        next_s.oe = !driver_tristate_enable;
        next_s.slow = rate_slow;

        if (s.irq_cnt != 5'h00 && next_s.irq_cnt == s.irq_cnt) begin
            next_s.irq_cnt = s.irq_cnt - 5'h01;
        end
        next_s.irq = (next_s.irq_cnt != 5'h00);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.empty <= 1'b1;
            s.phase <= ATX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // the tristate only gates the drivers; fifo and sequencing run on
    assign tx_fifo_empty_flag = s.empty;
    assign tx_fifo_half_flag  = s.half;
    assign tx_fifo_full_flag  = s.full;
    assign tx_full_pin        = s.full;
    assign bus_out_pos        = s.bus.pos;
    assign bus_out_neg        = s.bus.neg;
    assign protected_out_pos  = s.bus.pos;
    assign protected_out_neg  = s.bus.neg;
    assign driver_oe          = s.oe;
    assign slow_slope         = s.slow;
    assign receiver_one       = s.rx1;
    assign receiver_two       = s.rx2;
    assign tx_idle_irq_pin    = s.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence seq_irq_rise;
        $rose(tx_idle_irq_pin);
    endsequence

    sequence seq_irq_hold;
        tx_idle_irq_pin [*8];
    endsequence

    sequence seq_idle_no_start;
        (s.phase == ATX_IDLE) && !s.running && !cmd_valid && !cs_rise;
    endsequence

    sequence seq_last_bit_end;
        (s.phase == ATX_BIT) && tick && (s.bit_idx == 5'h1f)
        && (s.tick_cnt >= bit_ticks - 9'h001);
    endsequence

    sequence seq_gap_end;
        (s.phase == ATX_GAP) && tick && (s.tick_cnt >= gap_ticks - 9'h001);
    endsequence

    a_empty_flag: assert property (tx_fifo_empty_flag == (s.count == 6'h00))
        else $error("empty flag disagrees with fifo count");

    a_half_flag: assert property (tx_fifo_half_flag == (s.count > 6'h10))
        else $error("half flag disagrees with fifo count");

    a_full_pin: assert property (tx_full_pin |-> tx_fifo_full_flag && s.count == 6'h20)
        else $error("full pin without 32 words");

    a_push_count: assert property (
        cmd_valid && cmd_opcode == 8'h0c && !s.full && !pop
        |=> s.count == $past(s.count) + 6'h01 && s.mem[$past(s.wr_ptr)] == $past(cmd_data))
        else $error("accepted write not stored");

    a_full_drop: assert property (
        s.full && cmd_valid && cmd_opcode == 8'h0c && !pop |=> s.count == 6'h20
        && s.wr_ptr == $past(s.wr_ptr))
        else $error("write while full changed the fifo");

    a_parity_odd: assert property ($past(pop && parity_insert_enable) |-> ^s.shreg)
        else $error("loaded word lacks odd parity");

    a_loop_null: assert property (
        loopback_test_enable |=> !bus_out_pos && !bus_out_neg)
        else $error("bus active during loopback");

    a_loop_invert: assert property (
        loopback_test_enable |=> receiver_two == {receiver_one.neg, receiver_one.pos})
        else $error("receiver two not the complement of receiver one");

    a_tristate_oe: assert property (driver_tristate_enable |=> !driver_oe)
        else $error("drivers enabled while tristated");

    a_no_self_start: assert property (seq_idle_no_start |=> s.phase == ATX_IDLE)
        else $error("transmission began without a start");

    a_three_level: assert property (!(bus_out_pos && bus_out_neg))
        else $error("both line outputs high");

    a_irq_pulse: assert property (seq_irq_rise |-> seq_irq_hold)
        else $error("interrupt pulse shorter than expected");

    a_irq_width: assert property (
        seq_irq_rise |-> ##19 tx_idle_irq_pin ##1 !tx_idle_irq_pin)
        else $error("interrupt pulse not one timebase period");

    a_tick_period: assert property (tick |-> ##20 tick)
        else $error("timebase tick not every 20 clocks");

    a_idle_null: assert property ((s.phase == ATX_IDLE) |-> !bus_out_pos && !bus_out_neg)
        else $error("bus not null while idle");

    a_gap_null: assert property ((s.phase == ATX_GAP) |-> !bus_out_pos && !bus_out_neg)
        else $error("bus not null during word gap");

    a_null_half: assert property (
        (s.phase == ATX_BIT) && (s.tick_cnt >= $past(half_ticks)) |-> !bus_out_pos && !bus_out_neg)
        else $error("second half of a bit not null");

    a_data_half: assert property (
        (s.phase == ATX_BIT) && (s.tick_cnt < $past(half_ticks)) && !$past(loopback_test_enable)
        |-> (bus_out_pos == s.shreg[wire_order(s.bit_idx)]) && (bus_out_neg != bus_out_pos))
        else $error("data half of a bit not on the line");

    a_no_parity: assert property (pop && !parity_insert_enable |=> s.shreg == $past(head))
        else $error("word altered with parity off");

    a_fifo_order: assert property (
        pop |=> (s.shreg[30:0] == $past(head[30:0])) && (s.rd_ptr == $past(s.rd_ptr) + 5'h01))
        else $error("fifo words not taken in order");

    a_start_run: assert property (start && (s.count != 6'h00) |=> s.running)
        else $error("start with words queued did not run");

    a_drain_stop: assert property (
        pop && (s.count == 6'h01) && !push && !start |=> !s.running)
        else $error("run kept going after the fifo drained");

    a_run_pop: assert property (
        (s.phase == ATX_IDLE) && s.running && (s.count != 6'h00) |=> (s.phase == ATX_BIT))
        else $error("running with words queued but no word sent");

    a_gap_next: assert property (seq_gap_end ##0 (s.running && (s.count != 6'h00)) |=> s.phase == ATX_BIT)
        else $error("queued word not sent after the gap");

    a_gap_idle: assert property (
        seq_gap_end ##0 !(s.running && (s.count != 6'h00)) |=> s.phase == ATX_IDLE)
        else $error("line not idle after the last word");

    a_word_gap: assert property (seq_last_bit_end |=> (s.phase == ATX_GAP) && (s.tick_cnt == 9'h000))
        else $error("gap did not follow bit 32");

    a_slope_follow: assert property (!srst |=> slow_slope == $past(rate_slow))
        else $error("slope output does not follow the rate bit");

    a_oe_on: assert property (!driver_tristate_enable |=> driver_oe)
        else $error("drivers floated without tristate");

    a_rx_off: assert property (
        !loopback_test_enable |=> (receiver_one == LINE_NULL) && (receiver_two == LINE_NULL))
        else $error("receivers fed without loopback");

    a_count_max: assert property (s.count <= 6'h20)
        else $error("fifo count above depth");

endmodule : atx_transmitter

// File: atx_bus_rx.sv
// receiver model: decodes the three-level line back into 32-bit words
// assumes a released line reads null, sampled on the system clock
`timescale 1ns/1ps
module atx_bus_rx (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        pos,
    input  wire logic        neg,
    output logic [31:0]      word,
    output logic             got,
    output logic [15:0]      hi_len,
    output logic [15:0]      gap_len
);
    logic [15:0] run;
    logic [4:0]  n;
    logic        prev;

    always_ff @(posedge clk) begin
        got <= 1'b0;
        if (srst) begin
            n    <= 5'h00;
            prev <= 1'b0;
            run  <= 16'h0000;
        end else begin
            prev <= pos | neg;
            run  <= (prev == (pos | neg)) ? run + 16'h0001 : 16'h0001;
            if ((pos | neg) && !prev) begin
                // only the null run before bit 1 is a word gap
                if (n == 5'h00)
                    gap_len <= run;
                word[(n < 5'h08) ? 5'h07 - n : n] <= pos;
                n   <= n + 5'h01;
                got <= (n == 5'h1f);
            end
            if (prev && !(pos | neg))
                hi_len <= run;
        end
    end
endmodule : atx_bus_rx

// File: atx_transmitter_bench.sv
// self-checking bench for the transmit path, high speed only to keep runs short
// assumes the command port contract: one-cycle cmd_valid and cs_rise pulses
`timescale 1ns/1ps
module atx_transmitter_bench;
    import atx_pkg::*;
    logic clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cs_rise = 1'b0;
    logic [7:0] cmd_opcode = 8'h00;
    logic [31:0] cmd_data = 32'h0;
    logic parity_insert_enable = 1'b0, loopback_test_enable = 1'b0;
    logic auto_send_enable = 1'b0, driver_tristate_enable = 1'b0, rate_slow = 1'b0;
    logic empty, half, full, full_pin, pos, neg, ppos, pneg, oe, slope, irq, lb_q;
    logic got_bus, got_lb;
    logic [31:0] w_bus, w_lb;
    logic [15:0] hi_len, gap_len;
    atx_line_t rx_one, rx_two;
    int fails = 0, compares = 0, cycles = 0, n_bus = 0, irq_hi = 0;

    always #25 clk = ~clk;

    atx_transmitter i_dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_data(cmd_data), .cs_rise(cs_rise),
        .parity_insert_enable(parity_insert_enable),
        .loopback_test_enable(loopback_test_enable), .auto_send_enable(auto_send_enable),
        .driver_tristate_enable(driver_tristate_enable), .rate_slow(rate_slow),
        .tx_fifo_empty_flag(empty), .tx_fifo_half_flag(half), .tx_fifo_full_flag(full),
        .tx_full_pin(full_pin), .bus_out_pos(pos), .bus_out_neg(neg),
        .protected_out_pos(ppos), .protected_out_neg(pneg), .driver_oe(oe),
        .slow_slope(slope), .receiver_one(rx_one), .receiver_two(rx_two),
        .tx_idle_irq_pin(irq));
    // a floated driver leaves the terminated bus at null
    atx_bus_rx i_rx_bus (.clk(clk), .srst(srst), .pos(pos & oe), .neg(neg & oe),
        .word(w_bus), .got(got_bus), .hi_len(hi_len), .gap_len(gap_len));
    atx_bus_rx i_rx_lb (.clk(clk), .srst(srst), .pos(rx_one.pos), .neg(rx_one.neg),
        .word(w_lb), .got(got_lb), .hi_len(), .gap_len());

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task send(input logic [7:0] op, input logic [31:0] d);
        @(posedge clk);
        cmd_valid  <= 1'b1;
        cmd_opcode <= op;
        cmd_data   <= d;
        @(posedge clk);
        cmd_valid  <= 1'b0;
    endtask : send

    task cs_end;
        @(posedge clk);
        cs_rise <= 1'b1;
        @(posedge clk);
        cs_rise <= 1'b0;
    endtask : cs_end

    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    task do_reset;
        @(posedge clk);
        srst <= 1'b1;
        wait_cyc(6);
        srst <= 1'b0;
    endtask : do_reset

    task catch_word(input logic lb_path);
        int i;
        for (i = 0; i < 10000 && !(lb_path ? got_lb : got_bus); i++) @(negedge clk);
        if (i == 10000) begin
            fails++;
            $display("wrong value at %0t: no word arrived", $time);
        end
        @(negedge clk);
    endtask : catch_word

    always @(posedge clk) lb_q <= loopback_test_enable;

    always @(negedge clk) begin
        cycles++;
        if (got_bus) n_bus++;
        if (irq) irq_hi++;
        if (!srst) begin
            chk({30'h0, rx_two}, {30'h0, rx_one.neg, rx_one.pos}, "rx two");
            chk({30'h0, ppos, pneg}, {30'h0, pos, neg}, "copy");
            chk(pos & neg, 1'b0, "both high");
            if (lb_q && loopback_test_enable) chk({pos, neg}, 2'b00, "lb null");
        end
        if (cycles == 90000) begin
            fails++;
            $display("wrong value at %0t: timeout", $time);
            results();
        end
    end

    initial begin
        int i;
        logic [31:0] a, b, c, d;
        a = 32'ha5c3_0f17;
        b = 32'h0000_00e1;
        c = 32'h7fff_fffe;
        d = 32'h1234_5678;
        do_reset();
        @(negedge clk);
        chk({empty, half, full, full_pin}, 4'h8, "after reset");
        for (i = 1; i <= 33; i++) begin
            send(8'h0c, 32'h1000_0000 + i);
            repeat (2) @(negedge clk);
            chk(half, i > 16, "half");
            chk({full, full_pin}, {2{i >= 32}}, "full");
            chk(empty, 1'b0, "empty");
        end
        chk(n_bus, 32'h0, "no start");
        $display("test fill done");
        do_reset();
        parity_insert_enable <= 1'b1;
        send(8'h0c, a);
        send(8'h0c, b);
        wait_cyc(100);
        chk(n_bus, 32'h0, "waits for start");
        send(8'h40, 32'h0);
        send(8'h0c, c);
        catch_word(1'b0);
        chk(w_bus, {~^a[30:0], a[30:0]}, "parity a");
        chk(hi_len, 16'h0064, "bit half");
        catch_word(1'b0);
        chk(w_bus, {~^b[30:0], b[30:0]}, "parity b");
        chk(gap_len, 16'h0384, "word gap");
        catch_word(1'b0);
        chk(w_bus, {~^c[30:0], c[30:0]}, "appended");
        wait_cyc(2000);
        chk({pos, neg}, 2'b00, "idle");
        chk(irq_hi, 32'h14, "irq pulse");
        send(8'h0c, d);
        wait_cyc(8000);
        chk(n_bus, 32'h3, "no restart");
        loopback_test_enable <= 1'b1;
        send(8'h40, 32'h0);
        catch_word(1'b1);
        chk(w_lb, {~^d[30:0], d[30:0]}, "loopback");
        chk(n_bus, 32'h3, "bus quiet");
        $display("test manual done");
        wait_cyc(2000);
        loopback_test_enable   <= 1'b0;
        parity_insert_enable   <= 1'b0;
        auto_send_enable       <= 1'b1;
        driver_tristate_enable <= 1'b1;
        send(8'h0c, a);
        cs_end();
        wait_cyc(8000);
        chk({oe, empty}, 2'b01, "tristate");
        chk(n_bus, 32'h3, "floated");
        driver_tristate_enable <= 1'b0;
        send(8'h0c, 32'h8000_0001);
        cs_end();
        catch_word(1'b0);
        chk(w_bus, 32'h8000_0001, "no parity");
        wait_cyc(1);
        rate_slow <= 1'b1;
        wait_cyc(3);
        chk(slope, 1'b1, "slope");
        $display("test auto done");
        results();
    end
endmodule : atx_transmitter_bench
